// [pkg/tmr_defines.svh]
// Register map, field positions and reset values of the 16-bit timer
// How it works
// - Interval, capture and PWM modes from control
// - Reset zeroes control: interval, undivided, interrupts off
// - Counter counts only while run bit set
// - Writing one to clear bit zeroes counter
// - Match/capture request gated by its enable bit
// - Hardware sets match pending; software clears it
// - Overflow pending clears on service or write
// - Overflow request separate from match/capture request
// - Interval match raises request and clears counter
// - Interval output inverts on every match
// - PWM counter runs free, wrapping to zero
// - PWM output low when reference <= counter
// - PWM period is the full counter range
// - Capture edge loads counter into reference register
// - Capture mode raises overflow and capture requests
// - Capture pin used only when port select zero
// - Count clock is prescaled clock or external pin
// - 16-bit counter and comparator, byte-wide access
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_CTL_ADDR      8'hf2
`define TMR_PS_ADDR       8'hf3
`define TMR_CNTH_ADDR     8'hf4
`define TMR_CNTL_ADDR     8'hf5
`define TMR_REFH_ADDR     8'hf6
`define TMR_REFL_ADDR     8'hf7

`define TMR_CTL_RESET     8'h00
`define TMR_PS_RESET      8'h00
`define TMR_REF_RESET     16'h0000
`define TMR_UNMAPPED      8'h00

`define TMR_CLR_BIT       5
`define TMR_RUN_BIT       4
`define TMR_MIE_BIT       3
`define TMR_MPEND_BIT     1
`define TMR_OPEND_BIT     0
`define TMR_FIXED_MASK    8'h3b

`define TMR_MODE_LSB_DEF  6
`define TMR_OVFIE_BIT_DEF 2
`define TMR_PS_EXT_DEF    4
`define TMR_PS_EDGE_DEF   5
`define TMR_PS_SEL_MSB    3

`define TMR_MODE_INTERVAL 2'h0
`define TMR_MODE_CAPTURE  2'h1
`define TMR_MODE_PWM      2'h2

`define TMR_CNT_ZERO      16'h0000
`define TMR_CNT_MAX       16'hffff
`define TMR_CAP_SEL_PIN   2'h0

`endif

// [pkg/tmr_pkg.sv]
// Types shared by the timer modules
package tmr_pkg;

    typedef logic [7:0] tmr_byte_t;

    typedef enum logic [1:0] {
        TMR_INTERVAL,
        TMR_CAPTURE,
        TMR_PWM
    } tmr_mode_e;

    typedef struct packed {
        tmr_byte_t addr;
        tmr_byte_t wdata;
        logic      wr;
        logic      rd;
    } tmr_req_s;

    typedef struct packed {
        logic ovf;
        logic mcap;
    } tmr_irq_s;

endpackage

// [logic/tmr_prescaler.sv]
// Power-of-two clock divider giving a one-cycle count enable
`timescale 1ns/100ps
module tmr_prescaler
    import tmr_pkg::*;
#(
    parameter int SEL_W = 4
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Control
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] sel,
    // Enable out
    output logic                  tick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    generate
        if (SEL_W < 1 || SEL_W > 5) begin : g_bad_width
            $error("prescaler select width out of range");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    // Select 0 divides by one, select n by two to the n
    assign mask = CNT_W'((1 << sel) - 1);
    assign tick = run & ((cnt_r & mask) == mask);

    always_ff @(posedge mclk) begin
        if (rst || !run) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

endmodule

// [logic/tmr_timer.sv]
// 16-bit timer with interval, capture and PWM modes
`timescale 1ns/100ps
`include "tmr_defines.svh"
module tmr_timer
    import tmr_pkg::*;
#(
    parameter int MODE_LSB  = `TMR_MODE_LSB_DEF,
    parameter int OVFIE_BIT = `TMR_OVFIE_BIT_DEF,
    parameter int PS_EXT    = `TMR_PS_EXT_DEF,
    parameter int PS_EDGE   = `TMR_PS_EDGE_DEF
) (
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      rst,
    // Register access
    input  wire tmr_req_s  reg_req,
    output tmr_byte_t      reg_rdata_r,
    // Interrupt controller
    input  wire logic      overflow_service_ack,
    output tmr_irq_s       irq,
    // Pins
    input  wire logic      capture_input_pin,
    input  wire logic      external_count_clock,
    input  wire logic [1:0] port_three_cap_sel,
    output logic           timer_output_pin_r,
    output logic           pwm_output_pin_r
);
    // Elaboration checks on movable field positions
    localparam logic [7:0] MODE_MASK = 8'((3 << MODE_LSB));
    localparam logic [7:0] OIE_MASK  = 8'((1 << OVFIE_BIT));

    generate
        if (MODE_LSB < 0 || MODE_LSB > 6 || OVFIE_BIT < 0 || OVFIE_BIT > 7
            || (MODE_MASK & `TMR_FIXED_MASK) != 8'h00
            || (OIE_MASK & (MODE_MASK | `TMR_FIXED_MASK)) != 8'h00) begin : g_bad_ctl
            $error("control field positions overlap");
        end
        if (PS_EXT <= `TMR_PS_SEL_MSB || PS_EDGE <= `TMR_PS_SEL_MSB
            || PS_EXT > 7 || PS_EDGE > 7 || PS_EXT == PS_EDGE) begin : g_bad_ps
            $error("prescaler field positions overlap");
        end
    endgenerate

    function automatic tmr_mode_e decode_mode(input logic [1:0] code);
        case (code)
            `TMR_MODE_CAPTURE: decode_mode = TMR_CAPTURE;
            `TMR_MODE_PWM:     decode_mode = TMR_PWM;
            default:           decode_mode = TMR_INTERVAL;
        endcase
    endfunction

    function automatic logic hit(input tmr_req_s r, input tmr_byte_t a);
        hit = r.wr && (r.addr == a);
    endfunction

    // Stored state
    logic [1:0]  mode_code_r;
    logic        run_r;
    logic        mie_r;
    logic        oie_r;
    logic        mpend_r;
    logic        opend_r;
    tmr_byte_t   ps_r;
    logic [15:0] cnt_r;
    logic [15:0] ref_r;
    logic        toggle_r;
    logic        cap_s1_r;
    logic        cap_s2_r;
    logic        cap_s3_r;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic        ext_s3_r;

    // Decode
    wire         wr_ctl    = hit(reg_req, `TMR_CTL_ADDR);
    wire         wr_ps     = hit(reg_req, `TMR_PS_ADDR);
    wire         wr_refh   = hit(reg_req, `TMR_REFH_ADDR);
    wire         wr_refl   = hit(reg_req, `TMR_REFL_ADDR);
    wire         clr_pulse = wr_ctl && reg_req.wdata[`TMR_CLR_BIT];
    tmr_mode_e   mode;
    assign mode = decode_mode(mode_code_r);

    // Count enable
    logic        ps_tick;
    wire         ext_rise = ext_s2_r & ~ext_s3_r;
    wire         ext_sel  = ps_r[PS_EXT];
    wire         tick     = run_r & (ext_sel ? ext_rise : ps_tick);

    tmr_prescaler #(
        .SEL_W (`TMR_PS_SEL_MSB + 1)
    ) u_prescaler (
        .mclk (mclk),
        .rst  (rst),
        .run  (run_r & ~ext_sel),
        .sel  (ps_r[`TMR_PS_SEL_MSB:0]),
        .tick (ps_tick)
    );

    // Events
    wire         at_ref   = (cnt_r == ref_r);
    wire         at_max   = (cnt_r == `TMR_CNT_MAX);
    wire         match    = tick && at_ref && (mode != TMR_CAPTURE);
    wire         int_clr  = match && (mode == TMR_INTERVAL);
    wire         ovf_evt  = tick && at_max && !int_clr;
    wire         cap_edge = ps_r[PS_EDGE] ? (cap_s2_r & ~cap_s3_r)
                                          : (~cap_s2_r & cap_s3_r);
    wire         cap_evt  = (mode == TMR_CAPTURE) && cap_edge
                            && (port_three_cap_sel == `TMR_CAP_SEL_PIN);
    wire         mc_evt   = match || cap_evt;

    // Next counter value
    logic [15:0] cnt_nxt;
    assign cnt_nxt = clr_pulse ? `TMR_CNT_ZERO :
                     int_clr   ? `TMR_CNT_ZERO :
                     tick      ? cnt_r + 16'h0001 :
                                 cnt_r;

    // Pending flags: a set in the same cycle as a clear wins
    wire         mclr_sw  = wr_ctl && !reg_req.wdata[`TMR_MPEND_BIT];
    wire         oclr_sw  = wr_ctl && !reg_req.wdata[`TMR_OPEND_BIT];
    wire         mpend_nxt = mc_evt | (mpend_r & ~mclr_sw);
    wire         opend_nxt = ovf_evt | (opend_r & ~(oclr_sw | overflow_service_ack));

    // Requests to the interrupt controller
    assign irq.mcap = mpend_r & mie_r;
    assign irq.ovf  = opend_r & oie_r;

    // Control readback
    tmr_byte_t   ctl_view;
    always_comb begin
        ctl_view                      = 8'h00;
        ctl_view[MODE_LSB +: 2]       = mode_code_r;
        ctl_view[OVFIE_BIT]           = oie_r;
        ctl_view[`TMR_RUN_BIT]        = run_r;
        ctl_view[`TMR_MIE_BIT]        = mie_r;
        ctl_view[`TMR_MPEND_BIT]      = mpend_r;
        ctl_view[`TMR_OPEND_BIT]      = opend_r;
    end

    tmr_byte_t   rd_mux;
    assign rd_mux = (reg_req.addr == `TMR_CTL_ADDR)  ? ctl_view :
                    (reg_req.addr == `TMR_PS_ADDR)   ? ps_r :
                    (reg_req.addr == `TMR_CNTH_ADDR) ? cnt_r[15:8] :
                    (reg_req.addr == `TMR_CNTL_ADDR) ? cnt_r[7:0] :
                    (reg_req.addr == `TMR_REFH_ADDR) ? ref_r[15:8] :
                    (reg_req.addr == `TMR_REFL_ADDR) ? ref_r[7:0] :
                                                       `TMR_UNMAPPED;

    // Pin synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cap_s3_r <= 1'b0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            cap_s1_r <= capture_input_pin;
            cap_s2_r <= cap_s1_r;
            cap_s3_r <= cap_s2_r;
            ext_s1_r <= external_count_clock;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // Control and prescaler registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            {mode_code_r, run_r, mie_r, oie_r} <= '0;
            ps_r <= `TMR_PS_RESET;
        end else begin
            if (wr_ctl) begin
                mode_code_r <= reg_req.wdata[MODE_LSB +: 2];
                run_r       <= reg_req.wdata[`TMR_RUN_BIT];
                mie_r       <= reg_req.wdata[`TMR_MIE_BIT];
                oie_r       <= reg_req.wdata[OVFIE_BIT];
            end
            if (wr_ps) begin
                ps_r <= reg_req.wdata;
            end
        end
    end

    // Pending flags and counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            mpend_r <= 1'b0;
            opend_r <= 1'b0;
            cnt_r   <= `TMR_CNT_ZERO;
        end else begin
            mpend_r <= mpend_nxt;
            opend_r <= opend_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Reference register: capture has priority over a software write
    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_r <= `TMR_REF_RESET;
        end else if (cap_evt) begin
            ref_r <= cnt_r;
        end else begin
            if (wr_refh) begin
                ref_r[15:8] <= reg_req.wdata;
            end
            if (wr_refl) begin
                ref_r[7:0] <= reg_req.wdata;
            end
        end
    end

    // Output pins and read data
    always_ff @(posedge mclk) begin
        if (rst) begin
            toggle_r           <= 1'b0;
            timer_output_pin_r <= 1'b0;
            pwm_output_pin_r   <= 1'b0;
            reg_rdata_r        <= 8'h00;
        end else begin
            if (int_clr) begin
                toggle_r <= ~toggle_r;
            end
            timer_output_pin_r <= (mode == TMR_PWM) ? (ref_r > cnt_r) : toggle_r;
            pwm_output_pin_r   <= (mode == TMR_PWM) && (ref_r > cnt_r);
            if (reg_req.rd) begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

    // Checks
    a_reset_ctl_zero: assert property (@(posedge mclk) rst |=> ctl_view == 8'h00)
        else $error("control not zero after reset");

    a_stop_holds_cnt: assert property (@(posedge mclk) disable iff (rst)
        (!run_r && !clr_pulse && !int_clr) |=> cnt_r == $past(cnt_r))
        else $error("counter moved while stopped");

    a_clear_zeroes: assert property (@(posedge mclk) disable iff (rst)
        clr_pulse |=> cnt_r == `TMR_CNT_ZERO)
        else $error("clear bit did not zero counter");

    a_mcap_gate: assert property (@(posedge mclk) disable iff (rst)
        irq.mcap |-> (mie_r && mpend_r))
        else $error("match request without enable");

    a_mpend_sticks: assert property (@(posedge mclk) disable iff (rst)
        (mpend_r && !wr_ctl) |=> mpend_r)
        else $error("match pending cleared without software");

    a_mpend_set: assert property (@(posedge mclk) disable iff (rst)
        mc_evt |=> mpend_r)
        else $error("match or capture did not set pending");

    a_ovf_serviced: assert property (@(posedge mclk) disable iff (rst)
        (overflow_service_ack && !ovf_evt) |=> !opend_r)
        else $error("overflow pending not cleared on service");

    a_interval_clear: assert property (@(posedge mclk) disable iff (rst)
        (tick && at_ref && mode == TMR_INTERVAL) |=> (cnt_r == `TMR_CNT_ZERO) && mpend_r)
        else $error("interval match did not clear counter");

    a_interval_toggle: assert property (@(posedge mclk) disable iff (rst)
        int_clr |=> ##1 timer_output_pin_r != $past(timer_output_pin_r))
        else $error("output did not invert on match");

    a_pwm_wraps: assert property (@(posedge mclk) disable iff (rst)
        (mode == TMR_PWM && tick && at_max && !clr_pulse) |=> cnt_r == `TMR_CNT_ZERO && opend_r)
        else $error("pwm counter did not wrap with overflow");

    a_pwm_level: assert property (@(posedge mclk) disable iff (rst)
        (mode == TMR_PWM && !wr_ctl) |=> pwm_output_pin_r == $past(ref_r > cnt_r))
        else $error("pwm level wrong");

    a_capture_load: assert property (@(posedge mclk) disable iff (rst)
        cap_evt |=> (ref_r == $past(cnt_r)) && mpend_r)
        else $error("capture did not load counter");

    a_capture_gated: assert property (@(posedge mclk) disable iff (rst)
        (port_three_cap_sel != `TMR_CAP_SEL_PIN) |-> !cap_evt)
        else $error("capture taken with pin deselected");

endmodule

// [verification/tmr_pin_model.sv]
// Model of the capture source and the external count clock source
`timescale 1ns/100ps
module tmr_pin_model (
    // Clock
    input  wire logic mclk,
    // Pins
    output logic      capture_input_pin,
    output logic      external_count_clock
);
    initial begin
        capture_input_pin    = 1'b0;
        external_count_clock = 1'b0;
    end
    // Move the capture line, then let the synchroniser settle
    task automatic cap_level(input logic lvl);
        @(posedge mclk);
        capture_input_pin <= lvl;
        repeat (6) @(posedge mclk);
    endtask
    // Slow count clock bursts; the line rests low between bursts
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            external_count_clock <= 1'b1;
            repeat (3) @(posedge mclk);
            external_count_clock <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask
endmodule

// [verification/test_sixteen_bit_timer_capture_pwm.sv]
// Self-checking testbench of the 16-bit timer
`timescale 1ns/100ps
`include "tmr_defines.svh"
module test_sixteen_bit_timer_capture_pwm;
    import tmr_pkg::*;
    logic      mclk;
    logic      rst;
    tmr_req_s  reg_req;
    tmr_byte_t reg_rdata_r;
    logic      ack;
    tmr_irq_s  irq;
    logic      cap_pin;
    logic      ext_clk;
    logic [1:0] cap_sel;
    logic      tout;
    logic      pout;
    int        error_cnt;
    int        checks_done;

    tmr_timer i_dut (
        .mclk                 (mclk),
        .rst                  (rst),
        .reg_req              (reg_req),
        .reg_rdata_r          (reg_rdata_r),
        .overflow_service_ack (ack),
        .irq                  (irq),
        .capture_input_pin    (cap_pin),
        .external_count_clock (ext_clk),
        .port_three_cap_sel   (cap_sel),
        .timer_output_pin_r   (tout),
        .pwm_output_pin_r     (pout)
    );
    tmr_pin_model i_pins (
        .mclk                 (mclk),
        .capture_input_pin    (cap_pin),
        .external_count_clock (ext_clk)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (exp !== got) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input tmr_byte_t a, input tmr_byte_t d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input tmr_byte_t a, input string what, input tmr_byte_t exp);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req.rd <= 1'b0;
        #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata_r});
    endtask
    task automatic settle();
        @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        rd(`TMR_CTL_ADDR, "control", `TMR_CTL_RESET);
        chk("irq", 16'h0000, {14'h0000, irq});
        rd(8'h00, "unmapped", 8'h00);
        wr(`TMR_CNTL_ADDR, 8'haa);
        rd(`TMR_CNTL_ADDR, "count low", 8'h00);
    endtask
    task automatic t_ext_clock();
        wr(`TMR_REFH_ADDR, 8'hff);
        wr(`TMR_REFL_ADDR, 8'hff);
        wr(`TMR_PS_ADDR, 8'h10);
        wr(`TMR_CTL_ADDR, 8'h30);
        i_pins.ext_pulses(5);
        rd(`TMR_CNTL_ADDR, "external count", 8'h05);
    endtask
    task automatic t_run_clear();
        tmr_byte_t a;
        wr(`TMR_PS_ADDR, 8'h00);
        wr(`TMR_CTL_ADDR, 8'h30);
        repeat (9) @(posedge mclk);
        wr(`TMR_CTL_ADDR, 8'h00);
        rd(`TMR_CNTL_ADDR, "count", 8'h0b);
        a = reg_rdata_r;
        chk("counting", 16'h0001, {15'h0000, a != 8'h00});
        repeat (10) @(posedge mclk);
        rd(`TMR_CNTL_ADDR, "stopped count", a);
        wr(`TMR_CTL_ADDR, 8'h20);
        rd(`TMR_CNTL_ADDR, "cleared low", 8'h00);
        rd(`TMR_CNTH_ADDR, "cleared high", 8'h00);
    endtask
    task automatic t_interval();
        int n;
        logic lvl;
        wr(`TMR_REFH_ADDR, 8'h00);
        wr(`TMR_REFL_ADDR, 8'h05);
        wr(`TMR_CTL_ADDR, 8'h38);
        settle();
        lvl = tout;
        for (n = 0; n < 20 && tout === lvl; n++) settle();
        lvl = tout;
        for (n = 0; n < 20 && tout === lvl; n++) settle();
        chk("toggle half period", 16'd6, 16'(n));
        wr(`TMR_CTL_ADDR, 8'h0a);
        settle();
        chk("match irq", 16'h0001, {15'h0000, irq.mcap});
        wr(`TMR_CTL_ADDR, 8'h02);
        settle();
        chk("masked match irq", 16'h0000, {15'h0000, irq.mcap});
        rd(`TMR_CTL_ADDR, "pending kept", 8'h02);
        wr(`TMR_CTL_ADDR, 8'h00);
        rd(`TMR_CTL_ADDR, "pending cleared", 8'h00);
    endtask
    task automatic t_capture();
        wr(`TMR_PS_ADDR, 8'h20);
        wr(`TMR_REFH_ADDR, 8'h12);
        wr(`TMR_REFL_ADDR, 8'h34);
        wr(`TMR_CTL_ADDR, 8'h68);
        cap_sel <= 2'h1;
        i_pins.cap_level(1'b1);
        i_pins.cap_level(1'b0);
        rd(`TMR_REFL_ADDR, "deselected capture", 8'h34);
        rd(`TMR_CTL_ADDR, "no capture pending", 8'h48);
        cap_sel <= `TMR_CAP_SEL_PIN;
        i_pins.cap_level(1'b1);
        rd(`TMR_REFH_ADDR, "captured high", 8'h00);
        rd(`TMR_REFL_ADDR, "captured low", 8'h00);
        rd(`TMR_CTL_ADDR, "capture pending", 8'h4a);
        chk("capture irq", 16'h0001, {15'h0000, irq.mcap});
        wr(`TMR_REFL_ADDR, 8'h77);
        i_pins.cap_level(1'b0);
        rd(`TMR_REFL_ADDR, "falling ignored", 8'h77);
    endtask
    task automatic t_pwm();
        int hi_t;
        int hi_p;
        wr(`TMR_CTL_ADDR, 8'h00);
        wr(`TMR_REFH_ADDR, 8'h00);
        wr(`TMR_REFL_ADDR, 8'h03);
        wr(`TMR_CTL_ADDR, 8'hb4);
        repeat (20) @(posedge mclk);
        hi_t = 0;
        hi_p = 0;
        repeat (65536) begin
            settle();
            hi_t += int'(tout === 1'b1);
            hi_p += int'(pout === 1'b1);
        end
        chk("pwm high cycles", 16'd3, 16'(hi_p));
        chk("output high cycles", 16'd3, 16'(hi_t));
        wr(`TMR_CTL_ADDR, 8'h87);
        settle();
        chk("overflow irq", 16'h0002, {14'h0000, irq});
        rd(`TMR_CTL_ADDR, "pwm pendings", 8'h87);
        ack <= 1'b1;
        @(posedge mclk);
        ack <= 1'b0;
        rd(`TMR_CTL_ADDR, "serviced", 8'h86);
        chk("overflow irq off", 16'h0000, {15'h0000, irq.ovf});
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst     = 1'b1;
        reg_req = '0;
        ack     = 1'b0;
        cap_sel = 2'h0;
        error_cnt   = 0;
        checks_done = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_ext_clock();
        t_run_clear();
        t_interval();
        t_capture();
        t_pwm();
        wrap_up();
    end

    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
endmodule
